// ==== rtl/ppo_top.sv ====
// Functional notes
// - select bit one: pin follows generator
// - select bit zero: pin follows manual level
// - manual one drives pin active
// - manual zero drives pin inactive
// - levels bits 7..0, selects 15..8
`timescale 1ns/1ps
`default_nettype none
module ppo_top #(
  parameter int unsigned N = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [3:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [3:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic [N-1:0] gen_active,
  output logic [N-1:0]      pin_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0]  ovr_ctrl, next_ovr_ctrl;
  logic [15:0]  duty_one, next_duty_one;
  logic [7:0]   polarity, next_polarity;
  logic         aw_held, next_aw_held;
  logic         w_held, next_w_held;
  logic [3:0]   aw_addr, next_aw_addr;
  logic [31:0]  w_data, next_w_data;
  logic [3:0]   w_strb, next_w_strb;
  logic         bvalid, next_bvalid;
  logic [1:0]   bresp, next_bresp;
  logic         rvalid, next_rvalid;
  logic [31:0]  rdata, next_rdata;
  logic [1:0]   rresp, next_rresp;
  logic [N-1:0] mux_level;
  logic [N-1:0] next_pin;
  logic         do_write;
  logic         awready, next_awready;
  logic         wready, next_wready;
  logic         arready, next_arready;

  // readies leave flops; same timing as the held flags they mirror
  assign s_axi_awready = awready;
  assign s_axi_wready  = wready;
  assign s_axi_arready = arready;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign do_write      = aw_held && w_held && !bvalid;

  ////////////////////////////////////////////////////////////////////////////
  // write path; address and data taken in either order
  always_comb begin
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    next_ovr_ctrl = ovr_ctrl;
    next_duty_one = duty_one;
    next_polarity = polarity;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = ppo_pkg::RESP_OKAY;
      case ({aw_addr[3:2], 2'b00})
        ppo_pkg::OVR_CTRL_OFS: begin
          // byte lanes follow the field split
          if (w_strb[0]) next_ovr_ctrl[7:0]  = w_data[7:0];
          if (w_strb[1]) next_ovr_ctrl[15:8] = w_data[15:8];
        end
        ppo_pkg::DUTY_ONE_OFS: begin
          if (w_strb[0]) next_duty_one[7:0]  = w_data[7:0];
          if (w_strb[1]) next_duty_one[15:8] = w_data[15:8];
        end
        ppo_pkg::POLARITY_OFS: begin
          if (w_strb[0]) next_polarity = w_data[7:0];
        end
        ppo_pkg::PIN_STATE_OFS: begin
          // read-only status; write accepted, no effect
        end
        default: next_bresp = ppo_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // ready is the registered image of the next held state
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path; one cycle from address to data
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = ppo_pkg::RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        ppo_pkg::OVR_CTRL_OFS:  next_rdata = {16'h0000, ovr_ctrl};
        ppo_pkg::DUTY_ONE_OFS:  next_rdata = {16'h0000, duty_one};
        ppo_pkg::POLARITY_OFS:  next_rdata = {24'h000000, polarity};
        ppo_pkg::PIN_STATE_OFS: next_rdata = {24'h000000, pin_out};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = ppo_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  ppo_pin_mux #(
    .N (N)
  ) ppo_pin_mux_i (
    .select_bits (ovr_ctrl[ppo_pkg::SELECT_LSB +: N]),
    .level_bits  (ovr_ctrl[ppo_pkg::LEVEL_LSB +: N]),
    .gen_active  (gen_active),
    .invert      (polarity[N-1:0]),
    .pin_level   (mux_level)
  );

  // pins registered so outputs come from flops; one cycle of latency
  always_comb begin
    next_pin = mux_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_ctrl <= ppo_pkg::OVR_CTRL_RST;
      duty_one <= ppo_pkg::DUTY_ONE_RST;
      polarity <= ppo_pkg::POLARITY_RST;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= 4'h0;
      w_data   <= 32'h00000000;
      w_strb   <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= ppo_pkg::RESP_OKAY;
      rvalid   <= 1'b0;
      rdata    <= 32'h00000000;
      rresp    <= ppo_pkg::RESP_OKAY;
      pin_out  <= '0;
      awready  <= 1'b1;
      wready   <= 1'b1;
      arready  <= 1'b1;
    end else begin
      ovr_ctrl <= next_ovr_ctrl;
      duty_one <= next_duty_one;
      polarity <= next_polarity;
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      aw_addr  <= next_aw_addr;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      rvalid   <= next_rvalid;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
      pin_out  <= next_pin;
      awready  <= next_awready;
      wready   <= next_wready;
      arready  <= next_arready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_gen_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ovr_ctrl[8] |=> pin_out[0] == ($past(gen_active[0]) ^ $past(polarity[0])))
    else $error("pin 0 not following generator");
  a_manual_level: assert property (@(posedge aclk) disable iff (!aresetn)
    !ovr_ctrl[15] |=> pin_out[7] == ($past(ovr_ctrl[7]) ^ $past(polarity[7])))
    else $error("pin 7 not following manual level");
  a_manual_active: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ovr_ctrl[9] && ovr_ctrl[1] && !polarity[1]) |=> pin_out[1])
    else $error("manual active not driven");
  a_manual_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ovr_ctrl[10] && !ovr_ctrl[2] && !polarity[2]) |=> !pin_out[2])
    else $error("manual inactive not driven");
  a_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && aw_addr[3:2] == 2'b00 && w_strb[1:0] == 2'b11)
      |=> ovr_ctrl == $past(w_data[15:0]))
    else $error("override control write lost");
  a_duty_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && aw_addr[3:2] == 2'b01 && w_strb[1:0] == 2'b11)
      |=> duty_one == $past(w_data[15:0]))
    else $error("duty write lost");
  a_duty_reset: assert property (@(posedge aclk)
    !aresetn |=> duty_one == 16'h0000)
    else $error("duty not zero after reset");
  a_polarity_inv: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ovr_ctrl[11] && ovr_ctrl[3] && polarity[3]) |=> !pin_out[3])
    else $error("inverted active not low");
  a_resp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid && !s_axi_rready) |=> (rvalid && $stable(rdata)))
    else $error("read answer dropped");

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid && !s_axi_bready) |=> (bvalid && $stable(bresp)))
    else $error("write answer dropped");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> bvalid)
    else $error("write answer missing");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> rvalid)
    else $error("read answer missing");
  a_write_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write taken while answer pending");
  a_read_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  ////////////////////////////////////////////////////////////////////////////
  // register fields
  a_level_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && aw_addr[3:2] == 2'b00 && w_strb[1:0] == 2'b01)
      |=> ovr_ctrl == {$past(ovr_ctrl[15:8]), $past(w_data[7:0])})
    else $error("manual level lane write lost");
  a_read_lane: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'b00)
      |=> rdata == {16'h0000, $past(ovr_ctrl)})
    else $error("override control read wrong");
  a_ctrl_reset: assert property (@(posedge aclk)
    !aresetn |=> ovr_ctrl == ppo_pkg::OVR_CTRL_RST)
    else $error("override control reset value wrong");
  a_ovr_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    !do_write |=> $stable(ovr_ctrl))
    else $error("override control moved without write");
  a_duty_lane: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && aw_addr[3:2] == 2'b01 && w_strb[1:0] == 2'b10)
      |=> duty_one == {$past(w_data[15:8]), $past(duty_one[7:0])})
    else $error("duty upper lane write lost");
  a_duty_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'b01)
      |=> rdata == {16'h0000, $past(duty_one)})
    else $error("duty read wrong");
  a_duty_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    !do_write |=> $stable(duty_one))
    else $error("duty moved without write");
  a_pol_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    !do_write |=> $stable(polarity))
    else $error("polarity moved without write");
  a_state_ro: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && aw_addr[3:2] == 2'b11)
      |=> ($stable(ovr_ctrl) && $stable(duty_one) && $stable(polarity)))
    else $error("pin state write had an effect");
  a_pin_reset: assert property (@(posedge aclk)
    !aresetn |=> pin_out == '0)
    else $error("pins not low in reset");

  ////////////////////////////////////////////////////////////////////////////
  // every pin against its selected source
  genvar k;
  generate
    for (k = 0; k < N; k++) begin : g_pin_chk
      a_pin_path: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> pin_out[k] == (($past(ovr_ctrl[ppo_pkg::SELECT_LSB + k])
          ? $past(gen_active[k]) : $past(ovr_ctrl[ppo_pkg::LEVEL_LSB + k]))
          ^ $past(polarity[k])))
        else $error("pin not following its source");
    end
  endgenerate
endmodule : ppo_top
`default_nettype wire

// ==== rtl/ppo_pkg.sv ====
package ppo_pkg;
  localparam int unsigned ADDR_W        = 4;
  localparam logic [3:0]  OVR_CTRL_OFS  = 4'h0;
  localparam logic [3:0]  DUTY_ONE_OFS  = 4'h4;
  localparam logic [3:0]  POLARITY_OFS  = 4'h8;
  localparam logic [3:0]  PIN_STATE_OFS = 4'hC;
  localparam int unsigned LEVEL_LSB     = 0;
  localparam int unsigned SELECT_LSB    = 8;
  localparam int unsigned PIN_COUNT     = 8;
  localparam logic [15:0] OVR_CTRL_RST  = 16'hFF00;
  localparam logic [15:0] DUTY_ONE_RST  = 16'h0000;
  localparam logic [7:0]  POLARITY_RST  = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : ppo_pkg

// ==== rtl/ppo_pin_mux.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppo_pin_mux #(
  parameter int unsigned N = 8
) (
  input  wire logic [N-1:0] select_bits,
  input  wire logic [N-1:0] level_bits,
  input  wire logic [N-1:0] gen_active,
  input  wire logic [N-1:0] invert,
  output logic      [N-1:0] pin_level
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      logic active;
      // generator when selected, else manual level
      assign active = select_bits[i] ? gen_active[i] : level_bits[i];
      // active maps to high unless inverted
      assign pin_level[i] = active ^ invert[i];
    end
  endgenerate
endmodule : ppo_pin_mux
`default_nettype wire

// ==== bench/ppo_gate_drv.sv ====
`timescale 1ns/1ps
`default_nettype none
// gate driver stage: conducts while its input is high
// no inversion here, polarity is chosen upstream
module ppo_gate_drv #(
  parameter int unsigned N = 8
) (
  input  wire logic [N-1:0] pin_level,
  output logic      [N-1:0] gate_on
);
  assign gate_on = pin_level;
endmodule : ppo_gate_drv
`default_nettype wire

// ==== bench/test_pwm_pin_override.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_pwm_pin_override;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0]  bresp, rresp;
  logic [7:0]  gen, pins, gate;
  int          mismatches, n_tests;
  ppo_top ppo_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .gen_active(gen), .pin_out(pins));
  ppo_gate_drv ppo_gate_drv_i (.pin_level(pins), .gate_on(gate));
  ////////////////////////////////////////////////////////////////////
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // both halves offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_ok = 1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_ok = 1; wvalid <= 1'b0; end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    chk({30'h0, bresp}, {30'h0, ppo_pkg::RESP_OKAY});
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (!(arvalid && arready));
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    chk({30'h0, rresp}, {30'h0, ppo_pkg::RESP_OKAY});
    rready <= 1'b0;
  endtask : rd
  // pins registered: let the change land before looking
  task automatic pin_chk(input logic [15:0] ov, input logic [7:0] pol);
    logic [7:0] e;
    repeat (3) @(posedge aclk);
    // built only now: a gen change is still pending at entry
    e = ((ov[15:8] & gen) | (~ov[15:8] & ov[7:0])) ^ pol;
    chk({24'h0, gate}, {24'h0, e});
    rd(ppo_pkg::PIN_STATE_OFS, rd_v);
    chk(rd_v, {24'h0, e});
  endtask : pin_chk
  task automatic final_report;
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    final_report();
  end
  initial begin
    mismatches = 0; n_tests = 0; aresetn = 1'b0; gen = 8'h00;
    awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ppo_pkg::OVR_CTRL_OFS, rd_v);
    chk(rd_v, 32'h0000FF00);
    rd(ppo_pkg::DUTY_ONE_OFS, rd_v);
    chk(rd_v, 32'h00000000);
    rd(ppo_pkg::POLARITY_OFS, rd_v);
    chk(rd_v, 32'h00000000);
    gen <= 8'hA5;
    pin_chk(16'hFF00, 8'h00);
    wr(ppo_pkg::OVR_CTRL_OFS, 32'h00000F3C, 4'hF);
    pin_chk(16'h0F3C, 8'h00);
    rd(ppo_pkg::OVR_CTRL_OFS, rd_v);
    chk(rd_v, 32'h00000F3C);
    wr(ppo_pkg::OVR_CTRL_OFS, 32'h000000FF, 4'hF);
    pin_chk(16'h00FF, 8'h00);
    wr(ppo_pkg::OVR_CTRL_OFS, 32'h00000000, 4'hF);
    pin_chk(16'h0000, 8'h00);
    wr(ppo_pkg::POLARITY_OFS, 32'h000000FF, 4'hF);
    pin_chk(16'h0000, 8'hFF);
    gen <= 8'h5A;
    wr(ppo_pkg::OVR_CTRL_OFS, 32'h0000F0AC, 4'hF);
    pin_chk(16'hF0AC, 8'hFF);
    // low lane only: select bits must survive
    wr(ppo_pkg::OVR_CTRL_OFS, 32'h0000AA55, 4'h1);
    pin_chk(16'hF055, 8'hFF);
    rd(ppo_pkg::OVR_CTRL_OFS, rd_v);
    chk(rd_v, 32'h0000F055);
    // pin state is read-only: a write must change nothing
    wr(ppo_pkg::PIN_STATE_OFS, 32'h000000FF, 4'hF);
    pin_chk(16'hF055, 8'hFF);
    wr(ppo_pkg::DUTY_ONE_OFS, 32'h0000BEEF, 4'h3);
    rd(ppo_pkg::DUTY_ONE_OFS, rd_v);
    chk(rd_v, 32'h0000BEEF);
    wr(ppo_pkg::DUTY_ONE_OFS, 32'h00001200, 4'h2);
    rd(ppo_pkg::DUTY_ONE_OFS, rd_v);
    chk(rd_v, 32'h000012EF);
    final_report();
  end
endmodule : test_pwm_pin_override
`default_nettype wire
